// File: common/movie_timing_pkg.sv
// Package: register map, field positions and timing constants for movie timing
package movie_timing_pkg;
	// ----------------------------------------
	// Register offsets and reset values
	// ----------------------------------------
	localparam logic [7:0] OFS_MOVIE_MODE = 8'h02;
	localparam logic [7:0] OFS_FRAME_TIME = 8'h03;
	localparam logic [7:0] OFS_DISP_OPT = 8'h04;
	localparam logic [7:0] OFS_CURRENT = 8'h05;
	localparam logic [7:0] RST_FRAME_TIME = 8'h00;
	localparam logic [7:0] RST_DISP_OPT = 8'h20;
	localparam logic [7:0] RST_CURRENT = 8'h00;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int FT_FADE_BIT = 7;
	localparam int FT_DIR_BIT = 6;
	localparam int FT_BLOCK_BIT = 5;
	localparam int FT_SCROLL_BIT = 4;
	localparam int FT_DELAY_LSB = 0;
	localparam int DO_LOOPS_LSB = 5;
	localparam int DO_BLINK_BIT = 4;
	localparam int DO_SCAN_LSB = 0;
	localparam logic [2:0] LOOPS_ENDLESS = 3'h7;
	localparam logic [3:0] SCAN_MAX = 4'hb;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_NS = 10;
	// One hold step is 32.5 ms, in microseconds times ten
	localparam int HOLD_STEP_US10 = 325_000;
	localparam int HOLD_STEP_CYC = HOLD_STEP_US10 * 100 / CLK_NS;
	localparam int BLINK_SHORT_MS = 1500;
	localparam int BLINK_LONG_MS = 3000;
	localparam int BLINK_SHORT_CYC = BLINK_SHORT_MS * (CLK_HZ / 1000) / 2;
	localparam int BLINK_LONG_CYC = BLINK_LONG_MS * (CLK_HZ / 1000) / 2;
	localparam int REFRESH_HZ = 430;
	localparam int REFRESH_COLS = 12;
	localparam int COL_SLOT_CYC = CLK_HZ / (REFRESH_HZ * REFRESH_COLS);
endpackage : movie_timing_pkg

// File: rtl/movie_frame_timing_scroll_ctrl.sv
// Module: movie frame sequencing, scroll options, blink, scan and current
//
// Functional notes
// - Hold each frame code times 32.5 ms
// - Code zero shows each frame once
// - Bit 7 fades, never in block scroll
// - Bit 6 picks scroll direction left/right
// - Bit 5 selects full or five-LED blocks
// - Bit 4 enables scrolling during movie
// - Loops one to five, seven endless
// - Blink period 1.5 s or 3 s
// - Scan columns zero through limit value, at most 11
// - Fewer scanned columns raise refresh rate
// - Current code drives linear LED current
// - End-last picks first or last final frame
// - Movie starts at start slot, beats picture
`timescale 1ns/100ps
`default_nettype none
module movie_frame_timing_scroll_ctrl (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [7:0] rd_addr_in,
	input wire logic play_movie_in,
	input wire logic show_picture_in,
	input wire logic [5:0] movie_start_in,
	input wire logic [5:0] picture_frame_in,
	input wire logic [5:0] movie_frames_in,
	input wire logic end_last_in,
	output logic [7:0] rd_data_out,
	output logic [5:0] frame_out,
	output logic frame_valid_out,
	output logic playing_out,
	output logic movie_done_out,
	output logic fade_en_out,
	output logic scroll_en_out,
	output logic scroll_left_out,
	output logic scroll_block_out,
	output logic blink_phase_out,
	output logic [3:0] column_out,
	output logic [7:0] current_code_out
);
	import movie_timing_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_PICTURE, ST_PLAY, ST_DONE} play_e;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] frame_time_scroll_ctrl;
	logic [7:0] display_option_ctrl;
	logic [7:0] led_current_level;
	play_e state;
	play_e next_state;
	logic [5:0] frame_idx;
	logic [5:0] next_frame_idx;
	logic [2:0] loops_left;
	logic [2:0] next_loops_left;
	logic [3:0] hold_steps;
	logic [3:0] next_hold_steps;
	logic [3:0] scan_col;
	logic blink_phase;

	function automatic logic [5:0] last_offset(input logic [5:0] count);
		last_offset = (count == 6'h00) ? 6'h00 : count;
	endfunction

	wire wr_ft = wr_en_in && (wr_addr_in == OFS_FRAME_TIME);
	wire wr_do = wr_en_in && (wr_addr_in == OFS_DISP_OPT);
	wire wr_cur = wr_en_in && (wr_addr_in == OFS_CURRENT);

	wire [3:0] hold_code = frame_time_scroll_ctrl[FT_DELAY_LSB +: 4];
	wire [2:0] loops_code = display_option_ctrl[DO_LOOPS_LSB +: 3];
	wire [3:0] scan_code = display_option_ctrl[DO_SCAN_LSB +: 4];
	wire block_mode = frame_time_scroll_ctrl[FT_BLOCK_BIT];
	wire endless = (loops_code == LOOPS_ENDLESS);
	wire loops_valid = (loops_code != 3'h0) && (loops_code != 3'h6);
	wire [5:0] last_idx = last_offset(movie_frames_in);
	wire pass_end = (frame_idx >= last_idx);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			frame_time_scroll_ctrl <= RST_FRAME_TIME;
			display_option_ctrl <= RST_DISP_OPT;
			led_current_level <= RST_CURRENT;
		end
		else
		begin
			if (wr_ft)
				frame_time_scroll_ctrl <= wr_data_in;
			if (wr_do)
				display_option_ctrl <= wr_data_in;
			if (wr_cur)
				led_current_level <= wr_data_in;
		end
	end

	wire [7:0] rd_mux = (rd_addr_in == OFS_FRAME_TIME) ? frame_time_scroll_ctrl :
		(rd_addr_in == OFS_DISP_OPT) ? display_option_ctrl :
		(rd_addr_in == OFS_CURRENT) ? led_current_level : 8'h00;

	// ----------------------------------------
	// Time bases
	// ----------------------------------------
	logic step_tick;
	logic blink_tick;
	logic col_tick;
	wire [31:0] blink_period = display_option_ctrl[DO_BLINK_BIT] ?
		32'(BLINK_LONG_CYC) : 32'(BLINK_SHORT_CYC);
	wire in_play = (state == ST_PLAY);

	tick_divider #(.WIDTH(32)) u_step_div (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.run_in(in_play && (hold_code != 4'h0)),
		.period_in(32'(HOLD_STEP_CYC)),
		.tick_out(step_tick)
	);

	tick_divider #(.WIDTH(32)) u_blink_div (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.run_in(1'b1),
		.period_in(blink_period),
		.tick_out(blink_tick)
	);

	// Fixed column slot: fewer columns shorten the scan cycle
	tick_divider #(.WIDTH(32)) u_col_div (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.run_in(1'b1),
		.period_in(32'(COL_SLOT_CYC)),
		.tick_out(col_tick)
	);

	// ----------------------------------------
	// Frame sequencer
	// ----------------------------------------
	// Zero code advances each clock: every frame shown once, no hold
	wire hold_done = (hold_code == 4'h0) ? 1'b1 :
		(step_tick && (hold_steps + 4'h1 >= hold_code));

	always_comb
	begin
		next_state = state;
		next_frame_idx = frame_idx;
		next_loops_left = loops_left;
		next_hold_steps = hold_steps;
		case (state)
			ST_IDLE, ST_PICTURE, ST_DONE:
			begin
				if (play_movie_in && (state != ST_DONE))
				begin
					next_state = ST_PLAY;
					next_frame_idx = 6'h00;
					next_loops_left = loops_code;
					next_hold_steps = 4'h0;
				end
				else if (!play_movie_in)
					next_state = show_picture_in ? ST_PICTURE : ST_IDLE;
			end
			ST_PLAY:
			begin
				if (!play_movie_in)
					next_state = show_picture_in ? ST_PICTURE : ST_IDLE;
				else if (!loops_valid && !endless)
					next_state = ST_DONE;
				else if (hold_done)
				begin
					next_hold_steps = 4'h0;
					if (!pass_end)
						next_frame_idx = frame_idx + 6'h01;
					else if (endless)
						next_frame_idx = 6'h00;
					else if (loops_left <= 3'h1)
					begin
						next_state = ST_DONE;
						next_frame_idx = end_last_in ? last_idx : 6'h00;
					end
					else
					begin
						next_loops_left = loops_left - 3'h1;
						next_frame_idx = 6'h00;
					end
				end
				else if (step_tick)
					next_hold_steps = hold_steps + 4'h1;
			end
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state <= ST_IDLE;
			frame_idx <= 6'h00;
			loops_left <= 3'h0;
			hold_steps <= 4'h0;
		end
		else
		begin
			state <= next_state;
			frame_idx <= next_frame_idx;
			loops_left <= next_loops_left;
			hold_steps <= next_hold_steps;
		end
	end

	// ----------------------------------------
	// Scan and blink
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			scan_col <= 4'h0;
			blink_phase <= 1'b0;
		end
		else
		begin
			if (col_tick)
				scan_col <= (scan_col >= scan_code || scan_col >= SCAN_MAX) ?
					4'h0 : scan_col + 4'h1;
			if (blink_tick)
				blink_phase <= ~blink_phase;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	wire [5:0] shown = (state == ST_PICTURE) ? picture_frame_in :
		movie_start_in + frame_idx;

	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rd_data_out <= 8'h00;
			frame_out <= 6'h00;
			frame_valid_out <= 1'b0;
			playing_out <= 1'b0;
			movie_done_out <= 1'b0;
			fade_en_out <= 1'b0;
			scroll_en_out <= 1'b0;
			scroll_left_out <= 1'b0;
			scroll_block_out <= 1'b0;
			blink_phase_out <= 1'b0;
			column_out <= 4'h0;
			current_code_out <= 8'h00;
		end
		else
		begin
			rd_data_out <= rd_mux;
			frame_out <= shown;
			frame_valid_out <= (state != ST_IDLE);
			playing_out <= in_play;
			movie_done_out <= (state == ST_DONE);
			fade_en_out <= frame_time_scroll_ctrl[FT_FADE_BIT] &&
				!block_mode;
			scroll_en_out <= frame_time_scroll_ctrl[FT_SCROLL_BIT] &&
				in_play;
			scroll_left_out <= frame_time_scroll_ctrl[FT_DIR_BIT];
			scroll_block_out <= block_mode;
			blink_phase_out <= blink_phase;
			column_out <= scan_col;
			current_code_out <= led_current_level;
		end
	end
endmodule // movie_frame_timing_scroll_ctrl
`default_nettype wire

// File: rtl/tick_divider.sv
// Module: programmable divider producing a one-cycle enable pulse
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
	parameter int WIDTH = 32
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic [WIDTH-1:0] period_in,
	output logic tick_out
);
	logic [WIDTH-1:0] count;
	wire last_count = (count >= period_in - WIDTH'(1));

	// Refuse a counter too narrow to divide at all
	if (WIDTH < 2)
	begin : g_width_check
		$error("tick_divider WIDTH too small");
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			count <= '0;
			tick_out <= 1'b0;
		end
		else if (!run_in)
		begin
			count <= '0;
			tick_out <= 1'b0;
		end
		else
		begin
			count <= last_count ? '0 : count + WIDTH'(1);
			tick_out <= last_count;
		end
	end
endmodule // tick_divider
`default_nettype wire

// File: test/movie_frame_timing_scroll_ctrl_bench.sv
// Testbench: registers, scroll options and movie playback
`timescale 1ns/100ps
`default_nettype none
module movie_frame_timing_scroll_ctrl_bench;
	import movie_timing_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic wr_en_in;
	logic [7:0] wr_addr_in;
	logic [7:0] wr_data_in;
	logic [7:0] rd_addr_in;
	logic play_movie_in = 1'b0;
	logic show_picture_in = 1'b1;
	logic [5:0] movie_start_in = 6'h05;
	logic [5:0] picture_frame_in = 6'h20;
	logic [5:0] movie_frames_in = 6'h02;
	logic end_last_in = 1'b1;
	logic [7:0] rd_data_out;
	logic [5:0] frame_out;
	logic frame_valid_out;
	logic playing_out;
	logic movie_done_out;
	logic fade_en_out;
	logic scroll_en_out;
	logic scroll_left_out;
	logic scroll_block_out;
	logic blink_phase_out;
	logic [3:0] column_out;
	logic [7:0] current_code_out;
	logic [7:0] d;
	int errors = 0;
	int n_compared = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	movie_frame_timing_scroll_ctrl movie_frame_timing_scroll_ctrl_inst (.*);
	movie_host_model movie_host_model_inst (
		.clk_sys_in(clk_sys_in),
		.rd_data_in(rd_data_out),
		.wr_en_out(wr_en_in),
		.wr_addr_out(wr_addr_in),
		.wr_data_out(wr_data_in),
		.rd_addr_out(rd_addr_in)
	);
	task wr(input logic [7:0] a, input logic [7:0] v);
		movie_host_model_inst.wr(a, v);
	endtask
	task rd(input logic [7:0] a);
		movie_host_model_inst.rd(a, d);
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task t_regs;
		rd(OFS_FRAME_TIME);
		chk("frame_time", RST_FRAME_TIME, d);
		chk("picture", 8'h20, 8'(frame_out));
		chk("valid", 8'h01, 8'(frame_valid_out));
		rd(OFS_DISP_OPT);
		chk("disp_opt", RST_DISP_OPT, d);
		rd(OFS_CURRENT);
		chk("current", RST_CURRENT, d);
		wr(OFS_CURRENT, 8'hff);
		wr(OFS_MOVIE_MODE, 8'hff);
		rd(OFS_CURRENT);
		chk("current_rd", 8'hff, d);
		chk("current_out", 8'hff, current_code_out);
		rd(OFS_MOVIE_MODE);
		chk("unmapped", 8'h00, d);
	endtask
	task automatic t_opts;
		logic [7:0] v [4] = '{8'h80, 8'ha0, 8'h40, 8'h70};
		foreach (v[i])
		begin
			wr(OFS_FRAME_TIME, v[i]);
			rd(OFS_FRAME_TIME);
			chk("ft_rd", v[i], d);
			chk("fade", 8'(v[i][7] & ~v[i][5]), 8'(fade_en_out));
			chk("left", 8'(v[i][6]), 8'(scroll_left_out));
			chk("block", 8'(v[i][5]), 8'(scroll_block_out));
			chk("scroll", 8'h00, 8'(scroll_en_out));
		end
	endtask
	task automatic run(input logic [2:0] n, output int c);
		wr(OFS_DISP_OPT, {n, 5'h0b});
		play_movie_in = 1'b1;
		c = 0;
		for (int i = 0; i < 20 && playing_out !== 1'b1; i++)
			@(posedge clk_sys_in) #1;
		chk("start", 8'(movie_start_in), 8'(frame_out));
		while (playing_out === 1'b1 && c < 200)
		begin
			@(posedge clk_sys_in) #1;
			c++;
		end
		chk("done", 8'h01, 8'(movie_done_out));
	endtask
	task t_loops;
		int c1;
		int c3;
		wr(OFS_FRAME_TIME, 8'h10);
		run(3'h1, c1);
		chk("last", 8'h07, 8'(frame_out));
		chk("held", 8'h01, 8'(frame_valid_out));
		play_movie_in = 1'b0;
		repeat (4) @(posedge clk_sys_in) #1;
		run(3'h3, c3);
		chk("passes", 8'h06, 8'(c3 - c1));
		play_movie_in = 1'b0;
		end_last_in = 1'b0;
		repeat (4) @(posedge clk_sys_in) #1;
		run(3'h1, c1);
		chk("first", 8'h05, 8'(frame_out));
		play_movie_in = 1'b0;
		repeat (4) @(posedge clk_sys_in) #1;
	endtask
	task t_endless;
		wr(OFS_FRAME_TIME, 8'h11);
		wr(OFS_DISP_OPT, 8'hf0);
		play_movie_in = 1'b1;
		repeat (60) @(posedge clk_sys_in) #1;
		chk("endless", 8'h01, 8'(playing_out));
		chk("hold", 8'h05, 8'(frame_out));
		chk("scroll_on", 8'h01, 8'(scroll_en_out));
		rd(OFS_DISP_OPT);
		wr(OFS_DISP_OPT, 8'hc0);
		repeat (4) @(posedge clk_sys_in) #1;
		chk("stopped", 8'h00, 8'(playing_out));
		play_movie_in = 1'b0;
	endtask
	// Column scan: step, slot length and wrap at a lowered limit
	task automatic t_scan;
		logic [3:0] prev;
		int c;
		wr(OFS_DISP_OPT, 8'h2b);
		prev = column_out;
		c = 0;
		while (column_out === prev && c < 2 * COL_SLOT_CYC)
		begin
			@(posedge clk_sys_in) #1;
			c++;
		end
		chk("col_first", 8'h01, 8'(column_out));
		prev = column_out;
		c = 0;
		while (column_out === prev && c < 2 * COL_SLOT_CYC)
		begin
			@(posedge clk_sys_in) #1;
			c++;
		end
		chk("col_next", 8'h02, 8'(column_out));
		chk("col_slot", 8'h01, 8'(c == COL_SLOT_CYC));
		wr(OFS_DISP_OPT, 8'h21);
		prev = column_out;
		c = 0;
		while (column_out === prev && c < 2 * COL_SLOT_CYC)
		begin
			@(posedge clk_sys_in) #1;
			c++;
		end
		chk("col_wrap", 8'h00, 8'(column_out));
		// Half blink period is far longer than the whole run
		chk("blink", 8'h00, 8'(blink_phase_out));
	endtask
	task summarize;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk_sys_in);
		#1 rst_n_in = 1'b1;
		t_regs();
		t_opts();
		t_loops();
		t_endless();
		t_scan();
		summarize();
	end
	// Watchdog: three column slots for the scan test plus margin
	initial
	begin
		repeat (3 * COL_SLOT_CYC + 10_000) @(posedge clk_sys_in);
		errors++;
		summarize();
	end
endmodule // movie_frame_timing_scroll_ctrl_bench
`default_nettype wire

// File: test/movie_frame_timing_scroll_ctrl_chk.sv
// Checker: output relations of the movie timing block
`timescale 1ns/100ps
`default_nettype none
module movie_frame_timing_scroll_ctrl_chk
	import movie_timing_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [7:0] rd_addr_in,
	input wire logic play_movie_in,
	input wire logic [5:0] movie_start_in,
	input wire logic [5:0] movie_frames_in,
	input wire logic [7:0] rd_data_out,
	input wire logic [5:0] frame_out,
	input wire logic playing_out,
	input wire logic movie_done_out,
	input wire logic fade_en_out,
	input wire logic scroll_en_out,
	input wire logic scroll_left_out,
	input wire logic scroll_block_out,
	input wire logic [3:0] column_out,
	input wire logic [7:0] current_code_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	property p_fade;
		$past(rd_addr_in) == OFS_FRAME_TIME |->
			fade_en_out == (rd_data_out[7] && !rd_data_out[5]);
	endproperty
	a_fade: assert property (p_fade) else $error("fade");
	property p_opts;
		$past(rd_addr_in) == OFS_FRAME_TIME |->
			{scroll_left_out, scroll_block_out} == rd_data_out[6:5];
	endproperty
	a_opts: assert property (p_opts) else $error("scroll opts");
	property p_scroll;
		$past(rd_addr_in) == OFS_FRAME_TIME && scroll_en_out |->
			rd_data_out[4];
	endproperty
	a_scroll: assert property (p_scroll) else $error("scroll");
	property p_cur;
		$past(rd_addr_in) == OFS_CURRENT |->
			current_code_out == rd_data_out;
	endproperty
	a_cur: assert property (p_cur) else $error("current");
	property p_scan;
		column_out <= SCAN_MAX;
	endproperty
	a_scan: assert property (p_scan) else $error("column");
	property p_col_step;
		$changed(column_out) |->
			column_out == 4'h0 || column_out == $past(column_out) + 4'h1;
	endproperty
	a_col_step: assert property (p_col_step) else $error("step");
	property p_start;
		$rose(play_movie_in) && !playing_out && !movie_done_out |->
			##2 playing_out && frame_out == $past(movie_start_in, 2);
	endproperty
	a_start: assert property (p_start) else $error("start");
	property p_done;
		movie_done_out |-> !playing_out;
	endproperty
	a_done: assert property (p_done) else $error("done");
	property p_stop;
		$past(rd_addr_in) == OFS_DISP_OPT && playing_out &&
			rd_data_out[7:5] inside {3'h0, 3'h6} |-> ##[1:3] !playing_out;
	endproperty
	a_stop: assert property (p_stop) else $error("stop");
	property p_once;
		$past(rd_addr_in) == OFS_FRAME_TIME && rd_data_out[3:0] == 4'h0 &&
			playing_out && $past(playing_out) &&
			movie_frames_in != 6'h00 |->
			##[1:2] ($changed(frame_out) || !playing_out);
	endproperty
	a_once: assert property (p_once) else $error("frame once");
endmodule // movie_frame_timing_scroll_ctrl_chk
bind movie_frame_timing_scroll_ctrl
	movie_frame_timing_scroll_ctrl_chk movie_frame_timing_scroll_ctrl_chk_inst
	(.*);
`default_nettype wire

// File: test/movie_host_model.sv
// Host model driving the register write and read port
`timescale 1ns/100ps
`default_nettype none
module movie_host_model (
	input wire logic clk_sys_in,
	input wire logic [7:0] rd_data_in,
	output logic wr_en_out,
	output logic [7:0] wr_addr_out,
	output logic [7:0] wr_data_out,
	output logic [7:0] rd_addr_out
);
	initial
	begin
		wr_en_out = 1'b0;
		wr_addr_out = 8'h00;
		wr_data_out = 8'h00;
		rd_addr_out = 8'h03;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in) #1;
		wr_en_out = 1'b1;
		wr_addr_out = a;
		wr_data_out = d;
		@(posedge clk_sys_in) #1;
		wr_en_out = 1'b0;
		// Released data lines show a changed pattern
		wr_data_out = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_in) #1;
		rd_addr_out = a;
		repeat (2) @(posedge clk_sys_in);
		#1 d = rd_data_in;
	endtask
endmodule // movie_host_model
`default_nettype wire
